// ---- clock_source_pll_control_pkg.sv ----
// Constants for the clock source and PLL control block
`default_nettype none
package clock_source_pll_control_pkg;
  // ****************************
  // Register byte offsets
  // ****************************
  localparam logic [7:0] OFS_TRIM   = 8'h00;
  localparam logic [7:0] OFS_PLL    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // ****************************
  // Field positions
  // ****************************
  localparam int BIT_LOCK     = 0;
  localparam int BIT_PLL_ON   = 1;
  localparam int BIT_RATE     = 2;
  localparam int BIT_TRIM_RNG = 7;
  localparam int BIT_PLL_SYS  = 6;
  localparam int BIT_EXT_CLK  = 7;
  localparam int BIT_SLP_OFF  = 8;
  localparam int BIT_SU_RES   = 9;
  // ****************************
  // Reset values
  // ****************************
  localparam logic [7:0] TRIM_RESET = 8'h00;
  // ****************************
  // Clock source fuse codes
  // ****************************
  localparam logic [3:0] SRC_EXT_CLK = 4'h0;
  localparam logic [3:0] SRC_PLL_EXT = 4'h1;
  localparam logic [3:0] SRC_RC      = 4'h2;
  localparam logic [3:0] SRC_PLL_RC  = 4'h3;
  localparam logic [3:0] SRC_PLL_OSC = 4'h5;
  // ****************************
  // Sleep mode codes
  // ****************************
  localparam logic [2:0] SLP_POWER_DOWN = 3'h2;
  localparam logic [2:0] SLP_STANDBY    = 3'h6;
  // ****************************
  // PLL figures
  // ****************************
  localparam logic [3:0] REF_DIVIDE  = 4'h8;
  localparam logic [6:0] PLL_MULT    = 7'h40;
  localparam logic [6:0] RATE_HI_MHZ = 7'h40;
  localparam logic [6:0] RATE_LO_MHZ = 7'h20;
  localparam logic [7:0] RANGE_STEP  = 8'h40;
  // ****************************
  // Timing
  // ****************************
  localparam int CLK_MHZ      = 50;
  localparam int LOCK_TIME_MS = 100;
  localparam int LOCK_CYCLES  = LOCK_TIME_MS * 1000 * CLK_MHZ;
  localparam logic [14:0] WAKE_6   = 15'h0006;
  localparam logic [14:0] WAKE_1K  = 15'h0400;
  localparam logic [14:0] WAKE_16K = 15'h4000;
  localparam logic [4:0] RESET_BASE_CK = 5'h0e;
  // Extra reset delay in tenths of a millisecond
  localparam logic [9:0] DLY_0    = 10'h000;
  localparam logic [9:0] DLY_4    = 10'h028;
  localparam logic [9:0] DLY_4P1  = 10'h029;
  localparam logic [9:0] DLY_64   = 10'h280;
  localparam logic [9:0] DLY_65   = 10'h28a;
endpackage
`default_nettype wire

// ---- clock_source_pll_control.sv ----
// Clock source, RC trim and PLL control with a Wishbone slave
// Operation
// - Factory trim loads on first clock after reset, before software
// - Software trim writes retune RC oscillator
// - Top trim bit picks overlapping range
// - Low seven bits tune monotonically upward
// - PLL multiplies 1 MHz reference by 64
// - Fast clock tracks trim changes at once
// - Enable bit runs PLL and RC
// - PLL as system clock forces enable
// - Lock flag set after about 100 ms
// - Rate bit picks 64 or 32 MHz
// - Bits 7..3 of PLL register read zero
// - Power-down and standby stop reference, PLL
// - PLL source and start fuses pick delays
// - Code 0000 selects external clock input
// - External clock delays per start fuses
// - Clock-out fuse drives clock on pin
// - Clock out carries the divided clock
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`default_nettype none
module clock_source_pll_control #(
  parameter int LOCK_CYCLES = clock_source_pll_control_pkg::LOCK_CYCLES,
  parameter int CNT_W       = 23
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  output logic             o_wb_err,
  // Fuses and calibration
  input  wire logic [7:0]  i_factory_trim,
  input  wire logic [3:0]  i_clock_source_fuses,
  input  wire logic [1:0]  i_startup_time_fuses,
  input  wire logic        i_clock_out_fuse,
  // Sleep state
  input  wire logic        i_sleeping,
  input  wire logic [2:0]  i_sleep_mode,
  // Clock out pin
  input  wire logic        i_sys_clk_div,
  input  wire logic        i_io_out,
  input  wire logic        i_io_oe,
  output logic             o_clock_out_pin,
  output logic             o_clock_out_oe,
  // RC oscillator control
  output logic      [7:0]  o_rc_trim,
  output logic             o_trim_range_select,
  output logic      [6:0]  o_trim_fine_value,
  output logic      [7:0]  o_rc_freq_code,
  output logic             o_rc_on,
  output logic             o_ref_on,
  output logic      [3:0]  o_ref_divide,
  // PLL control
  output logic             o_pll_on,
  output logic             o_pll_run,
  output logic             o_pll_locked_flag,
  output logic             o_pll_rate_select,
  output logic      [6:0]  o_pll_mult,
  output logic      [6:0]  o_fast_clk_mhz,
  output logic      [8:0]  o_fast_freq_code,
  // Start-up delays
  output logic             o_ext_clock_sel,
  output logic      [14:0] o_wake_delay_ck,
  output logic      [4:0]  o_reset_delay_ck,
  output logic      [9:0]  o_reset_extra_tenth_ms,
  output logic             o_startup_reserved
);
  // ****************************
  // State
  // ****************************
  typedef enum logic [1:0] {
    PLL_OFF     = 2'b00,
    PLL_LOCKING = 2'b01,
    PLL_LOCKED  = 2'b10
  } pll_state_t;

  typedef struct packed {
    logic             loaded;
    logic             ack;
    logic             err;
    logic [31:0]      rdata;
    logic [7:0]       trim;
    logic             rate;
    logic             pll_on;
    pll_state_t       pll_st;
    logic [CNT_W-1:0] lock_cnt;
    logic [14:0]      wake;
    logic [9:0]       rst_dly;
    logic             su_res;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic       pll_sys;
  logic       ext_sel;
  logic       sleep_off;
  logic       pll_on_rd;
  logic       run;
  logic       req;
  logic [7:0] pll_rd;
  logic [7:0] freq;

  // ****************************
  // Source decode
  // ****************************
  assign pll_sys = (i_clock_source_fuses == clock_source_pll_control_pkg::SRC_PLL_RC)
                 | (i_clock_source_fuses == clock_source_pll_control_pkg::SRC_PLL_OSC)
                 | (i_clock_source_fuses == clock_source_pll_control_pkg::SRC_PLL_EXT);
  assign ext_sel = (i_clock_source_fuses == clock_source_pll_control_pkg::SRC_EXT_CLK)
                 | (i_clock_source_fuses == clock_source_pll_control_pkg::SRC_PLL_EXT);
  assign sleep_off = i_sleeping
                   & ((i_sleep_mode == clock_source_pll_control_pkg::SLP_POWER_DOWN)
                   |  (i_sleep_mode == clock_source_pll_control_pkg::SLP_STANDBY));
  assign pll_on_rd = st_reg.pll_on | pll_sys;
  assign run       = pll_on_rd & ~sleep_off;
  assign req       = i_wb_cyc & i_wb_stb & ~st_reg.ack & ~st_reg.err & st_reg.loaded;
  assign pll_rd    = {5'h00, st_reg.rate, pll_on_rd, st_reg.pll_st == PLL_LOCKED};
  // Upper range overlaps the lower one
  assign freq = {1'b0, st_reg.trim[6:0]}
              + (st_reg.trim[7] ? clock_source_pll_control_pkg::RANGE_STEP : 8'h00);

  // ****************************
  // Next state
  // ****************************
  always_comb begin
    st_next       = st_reg;
    st_next.ack   = 1'b0;
    st_next.err   = 1'b0;
    st_next.rdata = 32'h0000_0000;
    if (!st_reg.loaded) begin
      st_next.trim   = i_factory_trim;
      st_next.loaded = 1'b1;
    end
    if (req) begin
      if (i_wb_adr == clock_source_pll_control_pkg::OFS_TRIM) begin
        st_next.ack   = 1'b1;
        st_next.rdata = {24'h00_0000, st_reg.trim};
        if (i_wb_we && i_wb_sel[0]) begin
          st_next.trim = i_wb_dat[7:0];
        end
      end else if (i_wb_adr == clock_source_pll_control_pkg::OFS_PLL) begin
        st_next.ack   = 1'b1;
        st_next.rdata = {24'h00_0000, pll_rd};
        if (i_wb_we && i_wb_sel[0]) begin
          st_next.rate   = i_wb_dat[clock_source_pll_control_pkg::BIT_RATE];
          st_next.pll_on = i_wb_dat[clock_source_pll_control_pkg::BIT_PLL_ON];
        end
      end else if (i_wb_adr == clock_source_pll_control_pkg::OFS_STATUS) begin
        st_next.ack = 1'b1;
        st_next.rdata[3:0] = i_clock_source_fuses;
        st_next.rdata[5:4] = i_startup_time_fuses;
        st_next.rdata[clock_source_pll_control_pkg::BIT_PLL_SYS] = pll_sys;
        st_next.rdata[clock_source_pll_control_pkg::BIT_EXT_CLK] = ext_sel;
        st_next.rdata[clock_source_pll_control_pkg::BIT_SLP_OFF] = sleep_off;
        st_next.rdata[clock_source_pll_control_pkg::BIT_SU_RES]  = st_reg.su_res;
      end else begin
        st_next.err = 1'b1;
      end
    end
    // Lock detector, trim changes keep lock
    case (st_reg.pll_st)
      PLL_OFF: begin
        st_next.lock_cnt = '0;
        if (run) begin
          st_next.pll_st = PLL_LOCKING;
        end
      end
      PLL_LOCKING: begin
        if (!run) begin
          st_next.pll_st = PLL_OFF;
        end else if (st_reg.lock_cnt == CNT_W'(LOCK_CYCLES - 1)) begin
          st_next.pll_st = PLL_LOCKED;
        end else begin
          st_next.lock_cnt = st_reg.lock_cnt + CNT_W'(1);
        end
      end
      PLL_LOCKED: begin
        if (!run) begin
          st_next.pll_st = PLL_OFF;
        end
      end
      default: begin
        st_next.pll_st = PLL_OFF;
      end
    endcase
    // Start-up delay selection
    st_next.su_res = 1'b0;
    case (i_clock_source_fuses)
      clock_source_pll_control_pkg::SRC_PLL_RC: begin
        case (i_startup_time_fuses)
          2'h0: begin st_next.wake = clock_source_pll_control_pkg::WAKE_1K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_0; end
          2'h1: begin st_next.wake = clock_source_pll_control_pkg::WAKE_1K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_4; end
          2'h2: begin st_next.wake = clock_source_pll_control_pkg::WAKE_1K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_64; end
          default: begin st_next.wake = clock_source_pll_control_pkg::WAKE_16K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_0; end
        endcase
      end
      clock_source_pll_control_pkg::SRC_PLL_OSC: begin
        case (i_startup_time_fuses)
          2'h0: begin st_next.wake = clock_source_pll_control_pkg::WAKE_1K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_0; end
          2'h1: begin st_next.wake = clock_source_pll_control_pkg::WAKE_1K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_4; end
          2'h2: begin st_next.wake = clock_source_pll_control_pkg::WAKE_16K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_4; end
          default: begin st_next.wake = clock_source_pll_control_pkg::WAKE_16K; st_next.rst_dly = clock_source_pll_control_pkg::DLY_64; end
        endcase
      end
      clock_source_pll_control_pkg::SRC_PLL_EXT: begin
        st_next.wake = clock_source_pll_control_pkg::WAKE_6;
        case (i_startup_time_fuses)
          2'h0: st_next.rst_dly = clock_source_pll_control_pkg::DLY_0;
          2'h1: st_next.rst_dly = clock_source_pll_control_pkg::DLY_4;
          2'h2: st_next.rst_dly = clock_source_pll_control_pkg::DLY_64;
          default: begin st_next.rst_dly = clock_source_pll_control_pkg::DLY_0; st_next.su_res = 1'b1; end
        endcase
      end
      clock_source_pll_control_pkg::SRC_EXT_CLK: begin
        st_next.wake = clock_source_pll_control_pkg::WAKE_6;
        case (i_startup_time_fuses)
          2'h0: st_next.rst_dly = clock_source_pll_control_pkg::DLY_0;
          2'h1: st_next.rst_dly = clock_source_pll_control_pkg::DLY_4P1;
          2'h2: st_next.rst_dly = clock_source_pll_control_pkg::DLY_65;
          default: begin st_next.rst_dly = clock_source_pll_control_pkg::DLY_0; st_next.su_res = 1'b1; end
        endcase
      end
      default: begin
        st_next.wake    = clock_source_pll_control_pkg::WAKE_6;
        st_next.rst_dly = clock_source_pll_control_pkg::DLY_0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg          <= '0;
      st_reg.trim     <= clock_source_pll_control_pkg::TRIM_RESET;
      st_reg.pll_st   <= PLL_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************
  // Outputs
  // ****************************
  assign o_wb_dat            = st_reg.rdata;
  assign o_wb_ack            = st_reg.ack;
  assign o_wb_err            = st_reg.err;
  assign o_rc_trim           = st_reg.trim;
  assign o_trim_range_select = st_reg.trim[clock_source_pll_control_pkg::BIT_TRIM_RNG];
  assign o_trim_fine_value   = st_reg.trim[6:0];
  assign o_rc_freq_code      = freq;
  assign o_rc_on             = run | (i_clock_source_fuses == clock_source_pll_control_pkg::SRC_RC);
  assign o_ref_on            = run;
  assign o_ref_divide        = clock_source_pll_control_pkg::REF_DIVIDE;
  assign o_pll_on            = pll_on_rd;
  assign o_pll_run           = run;
  assign o_pll_locked_flag   = st_reg.pll_st == PLL_LOCKED;
  assign o_pll_rate_select   = st_reg.rate;
  assign o_pll_mult          = clock_source_pll_control_pkg::PLL_MULT;
  assign o_fast_clk_mhz      = st_reg.rate ? clock_source_pll_control_pkg::RATE_HI_MHZ
                                           : clock_source_pll_control_pkg::RATE_LO_MHZ;
  assign o_fast_freq_code    = st_reg.rate ? {freq, 1'b0} : {1'b0, freq};
  assign o_ext_clock_sel     = ext_sel;
  assign o_wake_delay_ck     = st_reg.wake;
  assign o_reset_delay_ck    = clock_source_pll_control_pkg::RESET_BASE_CK;
  assign o_reset_extra_tenth_ms = st_reg.rst_dly;
  assign o_startup_reserved  = st_reg.su_res;
  // Pin override holds through reset
  assign o_clock_out_pin = i_clock_out_fuse ? i_sys_clk_div : i_io_out;
  assign o_clock_out_oe  = i_clock_out_fuse | i_io_oe;

  // ****************************
  // Assertions
  // ****************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_pll_read;
    req && !i_wb_we && i_wb_adr == clock_source_pll_control_pkg::OFS_PLL;
  endsequence
  sequence s_trim_write;
    req && i_wb_we && i_wb_sel[0] && i_wb_adr == clock_source_pll_control_pkg::OFS_TRIM;
  endsequence

  a_trim_factory_load: assert property (!st_reg.loaded |=> o_rc_trim == $past(i_factory_trim))
    else $error("factory trim not loaded");
  a_trim_sw_write: assert property (s_trim_write |=> o_rc_trim == $past(i_wb_dat[7:0]) && o_wb_ack)
    else $error("trim write lost");
  a_range_overlap: assert property (o_rc_trim == 8'h80 |-> o_rc_freq_code < 8'h7f)
    else $error("ranges do not overlap");
  a_fine_monotonic: assert property ($changed(o_rc_trim) && o_trim_range_select == $past(o_trim_range_select)
      && o_trim_fine_value > $past(o_trim_fine_value) |-> o_rc_freq_code > $past(o_rc_freq_code))
    else $error("fine trim not monotonic");
  a_fast_tracks: assert property ($changed(o_rc_freq_code) |-> $changed(o_fast_freq_code))
    else $error("fast clock ignores trim");
  a_pll_force_on: assert property (pll_sys |-> o_pll_on)
    else $error("enable not forced");
  a_lock_delay: assert property ($rose(o_pll_locked_flag)
      |-> $past(st_reg.lock_cnt) == CNT_W'(LOCK_CYCLES - 1) && $past(run))
    else $error("lock too early");
  a_pll_reserved: assert property (s_pll_read ##1 o_wb_ack |-> o_wb_dat[31:3] == 29'h0)
    else $error("reserved bits set");
  a_sleep_stop: assert property (sleep_off |-> !o_ref_on && !o_pll_run)
    else $error("pll runs in deep sleep");
  a_lock_clear: assert property (!o_pll_run |=> !o_pll_locked_flag)
    else $error("lock kept while stopped");
  a_rate_mhz: assert property (o_pll_rate_select |-> o_fast_clk_mhz == 7'h40)
    else $error("wrong fast rate");
  a_clock_out: assert property (i_clock_out_fuse |-> o_clock_out_oe && o_clock_out_pin == i_sys_clk_div)
    else $error("clock out missing");
endmodule
`default_nettype wire

// ---- test_clock_source_pll_control.sv ----
// Self-checking testbench for the clock source and PLL control block
`default_nettype none
module test_clock_source_pll_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK_N = 20;
  // ****************************
  // Signals
  // ****************************
  logic        i_clk, i_reset, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_wb_err;
  logic [7:0]  i_wb_adr, i_factory_trim, o_rc_trim, o_rc_freq_code;
  logic [3:0]  i_wb_sel, i_clock_source_fuses, o_ref_divide;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic [1:0]  i_startup_time_fuses;
  logic [2:0]  i_sleep_mode;
  logic        i_clock_out_fuse, i_sleeping, i_sys_clk_div, i_io_out, i_io_oe;
  logic        o_clock_out_pin, o_clock_out_oe, o_trim_range_select, o_rc_on, o_ref_on;
  logic        o_pll_on, o_pll_run, o_pll_locked_flag, o_pll_rate_select, o_ext_clock_sel, o_startup_reserved;
  logic [6:0]  o_trim_fine_value, o_pll_mult, o_fast_clk_mhz;
  logic [8:0]  o_fast_freq_code;
  logic [14:0] o_wake_delay_ck;
  logic [4:0]  o_reset_delay_ck;
  logic [9:0]  o_reset_extra_tenth_ms;
  logic [32:0] exp_q[$];
  logic [32:0] mon_exp;
  int          num_errors = 0;
  int          tests_run = 0;
  clock_source_pll_control #(.LOCK_CYCLES(LOCK_N), .CNT_W(23)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err), .i_factory_trim(i_factory_trim),
    .i_clock_source_fuses(i_clock_source_fuses), .i_startup_time_fuses(i_startup_time_fuses),
    .i_clock_out_fuse(i_clock_out_fuse), .i_sleeping(i_sleeping), .i_sleep_mode(i_sleep_mode),
    .i_sys_clk_div(i_sys_clk_div), .i_io_out(i_io_out), .i_io_oe(i_io_oe),
    .o_clock_out_pin(o_clock_out_pin), .o_clock_out_oe(o_clock_out_oe), .o_rc_trim(o_rc_trim),
    .o_trim_range_select(o_trim_range_select), .o_trim_fine_value(o_trim_fine_value),
    .o_rc_freq_code(o_rc_freq_code), .o_rc_on(o_rc_on), .o_ref_on(o_ref_on), .o_ref_divide(o_ref_divide),
    .o_pll_on(o_pll_on), .o_pll_run(o_pll_run), .o_pll_locked_flag(o_pll_locked_flag),
    .o_pll_rate_select(o_pll_rate_select), .o_pll_mult(o_pll_mult), .o_fast_clk_mhz(o_fast_clk_mhz),
    .o_fast_freq_code(o_fast_freq_code), .o_ext_clock_sel(o_ext_clock_sel), .o_wake_delay_ck(o_wake_delay_ck),
    .o_reset_delay_ck(o_reset_delay_ck), .o_reset_extra_tenth_ms(o_reset_extra_tenth_ms),
    .o_startup_reserved(o_startup_reserved));
  // ****************************
  // Clock, watchdog, verdict
  // ****************************
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    end_of_test();
  end
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // ****************************
  // Wishbone master and read monitor
  // ****************************
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_dat <= dat;
    i_wb_sel <= sel;
    do begin
      @(posedge i_clk);
      n++;
    end while (!(o_wb_ack === 1'b1 || o_wb_err === 1'b1) && n < 50);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic wb_read(input logic [7:0] adr, input logic [32:0] exp);
    exp_q.push_back(exp);
    wb_cycle(1'b0, adr, 32'h0, 4'hf);
  endtask
  always @(posedge i_clk) begin
    if ((o_wb_ack === 1'b1 || o_wb_err === 1'b1) && i_wb_we === 1'b0 && exp_q.size() > 0) begin
      mon_exp = exp_q.pop_front();
      check("read_data", {31'h0, o_wb_err, o_wb_dat}, {31'h0, mon_exp});
    end
  end
  task automatic wait_lock(output int n);
    n = 0;
    while (o_pll_locked_flag !== 1'b1 && n < LOCK_N + 10) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  function automatic logic [25:0] exp_dly(input logic [3:0] c, input logic [1:0] s);
    logic [14:0] w;
    logic [9:0]  x;
    w = (s == 2'h3) ? clock_source_pll_control_pkg::WAKE_16K : clock_source_pll_control_pkg::WAKE_1K;
    x = (s == 2'h1) ? clock_source_pll_control_pkg::DLY_4 :
        (s == 2'h2) ? clock_source_pll_control_pkg::DLY_64 : clock_source_pll_control_pkg::DLY_0;
    if (c == clock_source_pll_control_pkg::SRC_PLL_OSC) begin
      w = s[1] ? clock_source_pll_control_pkg::WAKE_16K : clock_source_pll_control_pkg::WAKE_1K;
      x = (s == 2'h0) ? clock_source_pll_control_pkg::DLY_0 :
          (s == 2'h3) ? clock_source_pll_control_pkg::DLY_64 : clock_source_pll_control_pkg::DLY_4;
    end else if (c == clock_source_pll_control_pkg::SRC_EXT_CLK) begin
      w = clock_source_pll_control_pkg::WAKE_6;
      x = (s == 2'h1) ? clock_source_pll_control_pkg::DLY_4P1 :
          (s == 2'h2) ? clock_source_pll_control_pkg::DLY_65 : clock_source_pll_control_pkg::DLY_0;
    end else if (c == clock_source_pll_control_pkg::SRC_PLL_EXT) begin
      w = clock_source_pll_control_pkg::WAKE_6;
    end
    return {(c <= 4'h1 && s == 2'h3), w, x};
  endfunction
  // ****************************
  // Main sequence
  // ****************************
  initial begin
    logic [7:0]  t, f, f7f, f80;
    logic [25:0] d;
    logic [3:0]  c;
    logic [2:0]  modes[3];
    int          n;
    void'($urandom(32'h51cf));
    modes = '{clock_source_pll_control_pkg::SLP_POWER_DOWN, clock_source_pll_control_pkg::SLP_STANDBY, 3'h0};
    i_reset = 1'b1;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = '0;
    i_factory_trim = 8'($urandom);
    {i_clock_source_fuses, i_startup_time_fuses, i_sleeping, i_sleep_mode} = '0;
    {i_clock_out_fuse, i_sys_clk_div, i_io_out, i_io_oe} = 4'h9;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    check("clk_out_in_reset", {o_clock_out_pin, o_clock_out_oe}, {i_sys_clk_div, 1'b1});
    @(posedge i_clk);
    i_reset <= 1'b0;
    wb_read(clock_source_pll_control_pkg::OFS_TRIM, {25'h0, i_factory_trim});
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom);
      f = {1'b0, t[6:0]} + (t[7] ? clock_source_pll_control_pkg::RANGE_STEP : 8'h00);
      wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_TRIM, {24'h0, t}, 4'h1);
      @(negedge i_clk);
      check("trim", {o_rc_trim, o_trim_range_select, o_trim_fine_value}, {t, t[7], t[6:0]});
      check("rc_freq", o_rc_freq_code, f);
      if (i == 0) f7f = o_rc_freq_code;
      if (i == 1) f80 = o_rc_freq_code;
    end
    check("range_overlap", f7f > f80, 1'b1);
    wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_TRIM, {24'h0, ~t}, 4'he);
    wb_read(clock_source_pll_control_pkg::OFS_TRIM, {25'h0, t});
    wb_read(8'h0c, {1'b1, 32'h0});
    check("rc_idle", o_rc_on, 1'b0);
    wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_PLL, 32'hff, 4'h1);
    @(negedge i_clk);
    check("pll_start", {o_pll_on, o_pll_run, o_rc_on, o_ref_on, o_pll_locked_flag}, 5'h1e);
    check("pll_ratio", {o_ref_divide, o_pll_mult}, {4'h8, 7'h40});
    wait_lock(n);
    check("lock_delay", (n >= LOCK_N - 3 && n <= LOCK_N + 3), 1'b1);
    wb_read(clock_source_pll_control_pkg::OFS_PLL, {1'b0, 32'h07});
    t = 8'($urandom);
    f = {1'b0, t[6:0]} + (t[7] ? clock_source_pll_control_pkg::RANGE_STEP : 8'h00);
    wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_TRIM, {24'h0, t}, 4'h1);
    @(negedge i_clk);
    check("fast_hi", {o_fast_clk_mhz, o_fast_freq_code, o_pll_locked_flag}, {7'h40, f, 1'b0, 1'b1});
    wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_PLL, 32'h02, 4'h1);
    @(negedge i_clk);
    check("fast_lo", {o_fast_clk_mhz, o_fast_freq_code}, {7'h20, 1'b0, f});
    foreach (modes[m]) begin
      @(posedge i_clk);
      i_sleeping   <= 1'b1;
      i_sleep_mode <= modes[m];
      repeat (2) @(negedge i_clk);
      check("sleep_stop", {o_pll_run, o_ref_on, o_pll_locked_flag}, (m < 2) ? 3'h0 : 3'h7);
      @(posedge i_clk);
      i_sleeping <= 1'b0;
      wait_lock(n);
    end
    wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_PLL, 32'h00, 4'h1);
    repeat (2) @(negedge i_clk);
    check("pll_off", {o_pll_on, o_pll_run, o_rc_on, o_pll_locked_flag}, 4'h0);
    foreach (modes[k]) begin
      c = (k == 0) ? clock_source_pll_control_pkg::SRC_PLL_RC :
          (k == 1) ? clock_source_pll_control_pkg::SRC_PLL_OSC : clock_source_pll_control_pkg::SRC_PLL_EXT;
      for (int s = 0; s < 5; s++) begin
        @(posedge i_clk);
        i_clock_source_fuses <= (s == 4) ? clock_source_pll_control_pkg::SRC_EXT_CLK : c;
        i_startup_time_fuses <= 2'(s);
        repeat (2) @(negedge i_clk);
        d = exp_dly(i_clock_source_fuses, 2'(s));
        check("startup", {o_startup_reserved, o_reset_delay_ck, o_ext_clock_sel},
              {d[25], 5'h0e, i_clock_source_fuses[3:1] == 3'h0});
        if (!d[25]) check("delays", {o_wake_delay_ck, o_reset_extra_tenth_ms}, d[24:0]);
        wb_read(clock_source_pll_control_pkg::OFS_STATUS,
                {23'h0, d[25], 1'b0, i_clock_source_fuses[3:1] == 3'h0, s < 4, 2'(s),
                 i_clock_source_fuses});
      end
    end
    i_clock_source_fuses <= clock_source_pll_control_pkg::SRC_PLL_RC;
    wb_cycle(1'b1, clock_source_pll_control_pkg::OFS_PLL, 32'h00, 4'h1);
    wait_lock(n);
    wb_read(clock_source_pll_control_pkg::OFS_PLL, {1'b0, 32'h03});
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      {i_clock_out_fuse, i_sys_clk_div, i_io_out, i_io_oe} <= 4'($urandom);
      @(negedge i_clk);
      check("clk_out", {o_clock_out_pin, o_clock_out_oe},
            i_clock_out_fuse ? {i_sys_clk_div, 1'b1} : {i_io_out, i_io_oe});
    end
    repeat (2) @(posedge i_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
